/* File: timer_cfg.svh */
/*
 Register offsets, field positions, reset values and counts of the timer.
 Assumes inclusion by bare name from the timer module and the testbench.
*/
`ifndef TIMER_CFG_SVH
`define TIMER_CFG_SVH
`define OFS_CONTROL 5'h00
`define OFS_CMP_A 5'h04
`define OFS_CMP_B 5'h08
`define OFS_CAPTURE 5'h0C
`define OFS_PRESCALE 5'h10
`define OFS_COUNT 5'h14
`define BIT_CLR_IN_EN 20
`define BIT_RUN 15
`define BIT_CLK_SEL 14
`define BIT_EXT_EDGE 11
`define BIT_OUT_POL 9
`define BIT_PAUSE 8
`define BIT_MATCH_IE 7
`define BIT_CAP_IE 6
`define BIT_CLRIN_IE 5
`define BIT_STROBE 0
`define CTRL_RW_MASK 32'h001FFBE0
`define RST_CONTROL 32'h00000000
`define RST_CMP 16'hFFFF
`define RST_PRESCALE 8'hFF
`define START_TICKS 2
`endif

/* File: timer_pkg.sv */
/*
 Types shared by the timer: bus request carrier, modes and run states.
 Assumes timer_cfg.svh holds the numeric constants.
*/
`default_nettype none
package timer_pkg;
   typedef struct packed {
      logic [4:0] addr;
      logic [31:0] wdata;
      logic [3:0] be;
      logic wr;
      logic rd;
   } reg_req_type;
   typedef enum logic [1:0] {
      MODE_INTERVAL = 2'h0,
      MODE_CAPTURE = 2'h1,
      MODE_PULSE_ONCE = 2'h2,
      MODE_PULSE_REPEAT = 2'h3
   } mode_type;
   typedef enum logic [2:0] {
      IDLE_S = 3'h1,
      ARM_S = 3'h2,
      RUN_S = 3'h4
   } run_state_type;
endpackage : timer_pkg
`default_nettype wire

/* File: timer_capture_pulse_unit.sv */
/*
 Single channel 16-bit timer with prescaler, capture, counter clear input and
 programmable pulse output, reached over a plain strobe register port.
 Assumes the register master on clk_sys; pins and oscillators are asynchronous.
*/
// Operation
// - Mode field: interval with toggle, capture, one-shot pulse, repeating pulse.
// - Setting run enable clears counter and starts; clearing it stops the timer.
// - One-shot pulse mode clears run enable itself after one pulse.
// - First counter increment lags run enable by two or more counting clocks.
// - In deep sleep capture and clear-input events do not set flags.
// - Clear input enable lets a valid selected edge clear the counter.
// - Input source selects pin, sub oscillator or watchdog RC oscillator.
// - Edge polarity selects falling, rising or both edges; code 11 reserved.
// - Clock select picks prescaled internal clock or external clock input.
// - External edge bit picks falling or rising external clock edges.
// - Output polarity sets idle level and the opposite start level.
// - Pause holds the counter; clearing pause resumes from held value.
// - Separate enables gate match, capture and clear-input requests.
// - Request flags set on events and clear only by writing one.
// - Writing one to the clear bit resets counter and prescaler; reads zero.
// - B compare takes any 16-bit value; B match after that many clocks, except a B of 0 matches only when the count steps from FFFF.
// - Capture mode copies the counter into the capture register on an edge.
// - 16-bit up counter; internal clock is source divided by prescale plus one.
// - Both pulse modes drive a pulse width modulated waveform on the output.
// - All six registers are 32 bits with 32, 16 and 8 bit access.
// - Interval mode: counter equal to A raises match and restarts from zero.
// - Pulse modes: A compare sets period, B compare sets duty.
// - Capture mode drives no waveform on the pulse output.
`timescale 1ns/1ps
`default_nettype none
`include "timer_cfg.svh"
module timer_capture_pulse_unit #(
   parameter int CNT_W = 16,
   parameter int PRE_W = 8
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire timer_pkg::reg_req_type reg_req,
   output logic [31:0] reg_rdata,
   input wire logic ext_count_clock_pin,
   input wire logic capture_clear_pin,
   input wire logic external_sub_osc,
   input wire logic watchdog_rc_osc,
   input wire logic high_speed_rc_osc,
   input wire logic [1:0] prescale_source_select,
   input wire logic deep_sleep,
   output logic pulse_output_pin,
   output logic timer_request
);
   import timer_pkg::*;

   localparam int NSYNC = 5;

   logic [31:0] ctrl_q;
   logic [3:1] flag_q;
   logic [CNT_W-1:0] cmp_a_q;
   logic [CNT_W-1:0] cmp_b_q;
   logic [CNT_W-1:0] cap_q;
   logic [CNT_W-1:0] cnt_q;
   logic [PRE_W-1:0] pre_q;
   logic [PRE_W-1:0] pre_cnt_q;
   logic [1:0] arm_cnt_q;
   logic out_q;
   logic [31:0] rdata_q;
   run_state_type state_q;
   logic [NSYNC-1:0] meta_q;
   logic [NSYNC-1:0] sync_q;
   logic [NSYNC-1:0] last_q;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[8*i+:8] = nw[8*i+:8];
         end
      end
      return r;
   endfunction : merge

   function automatic logic edge_ok(input logic now, input logic was, input logic [1:0] pol);
      logic r;
      r = 1'b0;
      case (pol)
         2'h0: r = was & ~now;
         2'h1: r = now & ~was;
         2'h2: r = now ^ was;
         default: r = 1'b0;
      endcase
      return r;
   endfunction : edge_ok

   // The second and third stages together feed edge detection
   genvar g;
   generate
      for (g = 0; g < NSYNC; g++) begin : g_sync
         logic raw;
         if (g == 0) begin : g_ec
            assign raw = ext_count_clock_pin;
         end else if (g == 1) begin : g_pin
            assign raw = capture_clear_pin;
         end else if (g == 2) begin : g_xs
            assign raw = external_sub_osc;
         end else if (g == 3) begin : g_wd
            assign raw = watchdog_rc_osc;
         end else begin : g_hs
            assign raw = high_speed_rc_osc;
         end
         always_ff @(posedge clk_sys) begin
            if (rst) begin
               meta_q[g] <= 1'b0;
               sync_q[g] <= 1'b0;
               last_q[g] <= 1'b0;
            end else begin
               meta_q[g] <= raw;
               sync_q[g] <= meta_q[g];
               last_q[g] <= sync_q[g];
            end
         end
      end
   endgenerate

   mode_type mode;
   logic running;
   logic wr_ctrl;
   logic strobe;
   logic pre_src;
   logic pre_tick;
   logic ext_tick;
   logic count_tick;
   logic step;
   logic a_hit;
   logic b_hit;
   logic in_edge;
   logic clr_in;
   logic cap_evt;
   logic pulse_mode;
   logic pol;
   logic [31:0] ctrl_wr;

   assign mode = mode_type'(ctrl_q[13:12]);
   assign pol = ctrl_q[`BIT_OUT_POL];
   assign pulse_mode = ctrl_q[13];
   assign running = (state_q == RUN_S);
   assign wr_ctrl = reg_req.wr && (reg_req.addr == `OFS_CONTROL);
   assign ctrl_wr = merge(ctrl_q, reg_req.wdata, reg_req.be);
   assign strobe = wr_ctrl && reg_req.be[0] && reg_req.wdata[`BIT_STROBE];

   // Prescaler source: bus clock or rising edges of the high speed RC, sub or watchdog RC oscillator
   always_comb begin
      case (prescale_source_select)
         2'h1: pre_src = sync_q[4] & ~last_q[4];
         2'h2: pre_src = sync_q[2] & ~last_q[2];
         2'h3: pre_src = sync_q[3] & ~last_q[3];
         default: pre_src = 1'b1;
      endcase
   end

   assign pre_tick = pre_src && (pre_cnt_q == pre_q);
   assign ext_tick = ctrl_q[`BIT_EXT_EDGE] ? (sync_q[0] & ~last_q[0])
                                           : (last_q[0] & ~sync_q[0]);
   assign count_tick = ctrl_q[`BIT_CLK_SEL] ? ext_tick : pre_tick;
   assign step = running && !ctrl_q[`BIT_PAUSE] && count_tick;
   assign a_hit = step && (cnt_q == cmp_a_q);
   // B lands after B counting clocks, one tick earlier than an A compare of the same value would
   assign b_hit = step && pulse_mode && (cnt_q + CNT_W'(1) == cmp_b_q);

   always_comb begin
      case (ctrl_q[19:18])
         2'h1: in_edge = edge_ok(sync_q[2], last_q[2], ctrl_q[17:16]);
         2'h2: in_edge = edge_ok(sync_q[3], last_q[3], ctrl_q[17:16]);
         2'h0: in_edge = edge_ok(sync_q[1], last_q[1], ctrl_q[17:16]);
         default: in_edge = 1'b0;
      endcase
   end

   assign clr_in = running && in_edge && ctrl_q[`BIT_CLR_IN_EN];
   assign cap_evt = running && in_edge && (mode == MODE_CAPTURE);

   // Run enable; a software write in the one-shot finish cycle wins
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ctrl_q <= `RST_CONTROL;
      end else if (wr_ctrl) begin
         ctrl_q <= ctrl_wr & `CTRL_RW_MASK;
      end else if (a_hit && mode == MODE_PULSE_ONCE) begin
         ctrl_q[`BIT_RUN] <= 1'b0;
      end
   end

   // Event set wins over a write-one clear in the same cycle
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         flag_q <= 3'h0;
      end else begin
         for (int i = 1; i < 4; i++) begin
            if (wr_ctrl && reg_req.be[0] && reg_req.wdata[i]) begin
               flag_q[i] <= 1'b0;
            end
         end
         if (a_hit) begin
            flag_q[3] <= 1'b1;
         end
         if (cap_evt && !deep_sleep) begin
            flag_q[2] <= 1'b1;
         end
         if (clr_in && !deep_sleep) begin
            flag_q[1] <= 1'b1;
         end
      end
   end

   assign timer_request = |(flag_q & ctrl_q[7:5]);

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cmp_a_q <= `RST_CMP;
         cmp_b_q <= `RST_CMP;
         pre_q <= `RST_PRESCALE;
      end else if (reg_req.wr) begin
         case (reg_req.addr)
            `OFS_CMP_A: cmp_a_q <= CNT_W'(merge({16'h0000, cmp_a_q}, reg_req.wdata, reg_req.be));
            `OFS_CMP_B: cmp_b_q <= CNT_W'(merge({16'h0000, cmp_b_q}, reg_req.wdata, reg_req.be));
            `OFS_PRESCALE: pre_q <= PRE_W'(merge({24'h000000, pre_q}, reg_req.wdata, reg_req.be));
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state_q <= IDLE_S;
         arm_cnt_q <= 2'h0;
      end else begin
         case (state_q)
            IDLE_S: begin
               arm_cnt_q <= 2'h0;
               if (ctrl_q[`BIT_RUN]) begin
                  state_q <= ARM_S;
               end
            end
            ARM_S: begin
               if (!ctrl_q[`BIT_RUN]) begin
                  state_q <= IDLE_S;
               end else if (count_tick) begin
                  arm_cnt_q <= arm_cnt_q + 2'h1;
                  if (arm_cnt_q == 2'(`START_TICKS - 1)) begin
                     state_q <= RUN_S;
                  end
               end
            end
            RUN_S: begin
               if (!ctrl_q[`BIT_RUN]) begin
                  state_q <= IDLE_S;
               end
            end
            default: state_q <= IDLE_S;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         pre_cnt_q <= '0;
      end else if (strobe || state_q == IDLE_S || pre_tick) begin
         pre_cnt_q <= '0;
      end else if (pre_src) begin
         pre_cnt_q <= pre_cnt_q + PRE_W'(1);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cnt_q <= '0;
      end else if (state_q != RUN_S) begin
         if (state_q == ARM_S || ctrl_q[`BIT_RUN] || strobe) begin
            cnt_q <= '0;
         end
      end else if (strobe || clr_in || a_hit) begin
         cnt_q <= '0;
      end else if (step) begin
         cnt_q <= cnt_q + CNT_W'(1);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cap_q <= '0;
      end else if (cap_evt) begin
         cap_q <= cnt_q;
      end
   end

   // Output idles at polarity level, runs from the opposite start level
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         out_q <= 1'b0;
      end else if (state_q == IDLE_S || mode == MODE_CAPTURE) begin
         out_q <= pol;
      end else if (state_q == ARM_S) begin
         out_q <= ~pol;
      end else if (a_hit && mode == MODE_INTERVAL) begin
         out_q <= ~out_q;
      end else if (a_hit) begin
         out_q <= ~pol;
      end else if (b_hit) begin
         out_q <= pol;
      end
   end

   assign pulse_output_pin = out_q;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rdata_q <= 32'h00000000;
      end else if (reg_req.rd) begin
         case (reg_req.addr)
            `OFS_CONTROL: rdata_q <= {ctrl_q[31:4], flag_q, 1'b0};
            `OFS_CMP_A: rdata_q <= {16'h0000, cmp_a_q};
            `OFS_CMP_B: rdata_q <= {16'h0000, cmp_b_q};
            `OFS_CAPTURE: rdata_q <= {16'h0000, cap_q};
            `OFS_PRESCALE: rdata_q <= {24'h000000, pre_q};
            `OFS_COUNT: rdata_q <= {16'h0000, cnt_q};
            default: rdata_q <= 32'h00000000;
         endcase
      end else begin
         rdata_q <= 32'h00000000;
      end
   end

   assign reg_rdata = rdata_q;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   AST_TOGGLE: assert property (a_hit && mode == MODE_INTERVAL |=> out_q != $past(out_q))
      else $error("interval match did not toggle output");
   AST_START_CLEAR: assert property (state_q == IDLE_S && ctrl_q[`BIT_RUN] |=> cnt_q == '0 ##1 cnt_q == '0)
      else $error("start did not clear counter");
   AST_ONESHOT: assert property (a_hit && mode == MODE_PULSE_ONCE && !wr_ctrl |=> !ctrl_q[`BIT_RUN] ##1 state_q == IDLE_S)
      else $error("one-shot did not stop");
   AST_LATENCY: assert property ($rose(state_q == ARM_S) |-> !running [*2])
      else $error("counting started too early");
   AST_SLEEP: assert property (deep_sleep && !flag_q[2] && !flag_q[1] |=> !flag_q[2] && !flag_q[1])
      else $error("flag set in deep sleep");
   AST_CLR_IN: assert property (clr_in |=> cnt_q == '0)
      else $error("clear input ignored");
   AST_IDLE_LEVEL: assert property (state_q == IDLE_S ##1 state_q == IDLE_S |-> out_q == $past(pol))
      else $error("idle output level wrong");
   AST_PAUSE: assert property (running && ctrl_q[`BIT_PAUSE] && !strobe && !clr_in && ctrl_q[`BIT_RUN]
                               |=> cnt_q == $past(cnt_q))
      else $error("counter moved while paused");
   AST_FLAG_HOLD: assert property (flag_q[3] && !(wr_ctrl && reg_req.be[0] && reg_req.wdata[3]) |=> flag_q[3])
      else $error("match flag lost without clear");
   AST_STROBE: assert property (strobe |=> cnt_q == '0 && pre_cnt_q == '0)
      else $error("clear strobe ignored");
   AST_CAPTURE: assert property (cap_evt |=> cap_q == $past(cnt_q))
      else $error("capture value wrong");
   AST_PERIOD: assert property (a_hit && pulse_mode && !strobe |=> out_q == ~pol && cnt_q == '0)
      else $error("pulse period end wrong");

   COV_ONESHOT: cover property (a_hit && mode == MODE_PULSE_ONCE);
   COV_REPEAT_B: cover property (b_hit && mode == MODE_PULSE_REPEAT ##[1:1000] a_hit);
   COV_CAPTURE: cover property (cap_evt && !deep_sleep);
   COV_CLR_IN: cover property (clr_in);
endmodule : timer_capture_pulse_unit
`default_nettype wire

/* File: timer_pins_model.sv */
/*
 Far side of the timer: external count clock, capture/clear pin, free running
 oscillators, and a meter for the pulse output's high and low phase widths.
 Assumes it shares clk_sys with the timer and is steered by testbench calls.
*/
`timescale 1ns/1ps
`default_nettype none
module timer_pins_model (
   input wire logic clk_sys,
   input wire logic pulse_output_pin,
   output logic ext_count_clock_pin,
   output logic capture_clear_pin,
   output logic external_sub_osc,
   output logic watchdog_rc_osc,
   output logic high_speed_rc_osc,
   output logic [7:0] high_w,
   output logic [7:0] low_w
);
   logic [7:0] run_q = 8'h01;
   logic last_q = 1'b0;
   logic [3:0] osc_q = 4'h0;
   initial begin
      ext_count_clock_pin = 1'b0;
      capture_clear_pin = 1'b0;
      high_w = 8'h00;
      low_w = 8'h00;
   end
   // Slow oscillators, far inside what the synchroniser can follow
   assign external_sub_osc = osc_q[3];
   assign watchdog_rc_osc = osc_q[2];
   assign high_speed_rc_osc = osc_q[1];
   always @(posedge clk_sys) begin
      osc_q <= osc_q + 4'h1;
      if (pulse_output_pin === last_q) begin
         run_q <= run_q + 8'h01;
      end else begin
         if (last_q) begin
            high_w <= run_q;
         end else begin
            low_w <= run_q;
         end
         run_q <= 8'h01;
         last_q <= pulse_output_pin;
      end
   end
   // Four bus clocks per phase so no edge is lost in synchronising
   task automatic ext_toggle(input int n);
      repeat (n) begin
         repeat (4) @(posedge clk_sys);
         ext_count_clock_pin <= ~ext_count_clock_pin;
      end
      repeat (4) @(posedge clk_sys);
   endtask : ext_toggle
   task automatic cap_set(input logic v);
      @(posedge clk_sys);
      capture_clear_pin <= v;
   endtask : cap_set
endmodule : timer_pins_model
`default_nettype wire

/* File: timer_capture_pulse_unit_tb.sv */
/*
 Self-checking bench for the timer: register port tasks and directed tests.
 Assumes timer_cfg.svh, timer_pkg and the pin model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "timer_cfg.svh"
module timer_capture_pulse_unit_tb;
   import timer_pkg::*;
   localparam logic [31:0] RUN = 32'h1 << `BIT_RUN;
   localparam logic [31:0] CKX = 32'h1 << `BIT_CLK_SEL;
   localparam logic [31:0] EDG = 32'h1 << `BIT_EXT_EDGE;
   localparam logic [31:0] POL = 32'h1 << `BIT_OUT_POL;
   localparam logic [31:0] PAU = 32'h1 << `BIT_PAUSE;
   localparam logic [31:0] MIE = 32'h1 << `BIT_MATCH_IE;
   localparam logic [31:0] CIE = 32'h1 << `BIT_CAP_IE;
   localparam logic [31:0] LIE = 32'h1 << `BIT_CLRIN_IE;
   localparam logic [31:0] CLE = 32'h1 << `BIT_CLR_IN_EN;
   localparam logic [31:0] CAPR = 32'h00011000;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   reg_req_type req = '0;
   logic deep_sleep = 1'b0;
   logic [1:0] pre_sel = 2'h0;
   logic [31:0] rdata;
   logic [31:0] rd_val;
   logic out_pin, irq, ext_clk, cap_pin, sub_osc, wdt_osc, hs_osc;
   logic [7:0] high_w, low_w;
   int bad_count = 0;
   int tests_run = 0;
   always #50 clk_sys = ~clk_sys;
   timer_capture_pulse_unit timer_capture_pulse_unit_inst (.clk_sys(clk_sys), .rst(rst), .reg_req(req),
      .reg_rdata(rdata), .ext_count_clock_pin(ext_clk), .capture_clear_pin(cap_pin),
      .external_sub_osc(sub_osc), .watchdog_rc_osc(wdt_osc), .high_speed_rc_osc(hs_osc),
      .prescale_source_select(pre_sel), .deep_sleep(deep_sleep), .pulse_output_pin(out_pin),
      .timer_request(irq));
   timer_pins_model timer_pins_model_inst (.clk_sys(clk_sys), .pulse_output_pin(out_pin),
      .ext_count_clock_pin(ext_clk), .capture_clear_pin(cap_pin), .external_sub_osc(sub_osc),
      .watchdog_rc_osc(wdt_osc), .high_speed_rc_osc(hs_osc), .high_w(high_w), .low_w(low_w));
   task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] b = 4'hF);
      @(posedge clk_sys);
      req.addr <= a;
      req.wdata <= d;
      req.be <= b;
      req.wr <= 1'b1;
      @(posedge clk_sys);
      req.wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [4:0] a);
      @(posedge clk_sys);
      req.addr <= a;
      req.rd <= 1'b1;
      @(posedge clk_sys);
      req.rd <= 1'b0;
      #1;
      rd_val = rdata;
   endtask : rd
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %0t %s: got %h expected %h", $time, msg, got, exp);
      end
   endtask : chk
   task automatic chk_bit(input logic got, input logic exp, input string msg);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %0t %s: got %b expected %b", $time, msg, got, exp);
      end
   endtask : chk_bit
   task automatic chk_rd(input logic [4:0] a, input logic [31:0] exp, input string msg);
      rd(a);
      chk(rd_val, exp, msg);
   endtask : chk_rd
   // Flags cleared and mode set while stopped, then run
   task automatic start(input logic [31:0] c);
      wr(`OFS_CONTROL, c | 32'hE);
      wr(`OFS_CONTROL, c | RUN);
   endtask : start
   task automatic idle(input int n);
      repeat (n) @(posedge clk_sys);
   endtask : idle
   task automatic final_report;
      $display("Checks %0d, mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : final_report
   initial begin
      #(100 * 20000);
      bad_count++;
      $display("[FAIL] %0t watchdog expired", $time);
      final_report();
   end
   initial begin
      idle(10);
      rst <= 1'b0;
      chk_rd(`OFS_CONTROL, 32'h0, "control reset");
      chk_rd(`OFS_CMP_A, 32'h0000FFFF, "compare a reset");
      chk_rd(`OFS_CMP_B, 32'h0000FFFF, "compare b reset");
      chk_rd(`OFS_CAPTURE, 32'h0, "capture reset");
      chk_rd(`OFS_PRESCALE, 32'h000000FF, "prescale reset");
      chk_rd(`OFS_COUNT, 32'h0, "count reset");
      chk_rd(5'h18, 32'h0, "unmapped read");
      wr(`OFS_CAPTURE, 32'h00001234);
      chk_rd(`OFS_CAPTURE, 32'h0, "capture is read only");
      wr(`OFS_CMP_B, 32'hAAAA0012, 4'h1);
      wr(`OFS_CMP_B, 32'h00003400, 4'h2);
      chk_rd(`OFS_CMP_B, 32'h00003412, "byte lanes");
      chk_bit(out_pin, 1'b0, "idle level low");
      wr(`OFS_CONTROL, POL);
      idle(2);
      chk_bit(out_pin, 1'b1, "idle level high");
      $display("Test registers done");
      start(CKX | EDG);
      timer_pins_model_inst.ext_toggle(9);
      chk_rd(`OFS_COUNT, 32'h3, "rising ext count");
      start(CKX);
      timer_pins_model_inst.ext_toggle(7);
      chk_rd(`OFS_COUNT, 32'h2, "falling ext count");
      wr(`OFS_CONTROL, CKX | RUN | PAU);
      timer_pins_model_inst.ext_toggle(4);
      chk_rd(`OFS_COUNT, 32'h2, "paused count");
      wr(`OFS_CONTROL, CKX | RUN);
      timer_pins_model_inst.ext_toggle(4);
      chk_rd(`OFS_COUNT, 32'h4, "resumed count");
      wr(`OFS_CONTROL, CKX);
      timer_pins_model_inst.ext_toggle(4);
      chk_rd(`OFS_COUNT, 32'h4, "stopped count");
      wr(`OFS_CONTROL, CKX | 32'h1);
      chk_rd(`OFS_COUNT, 32'h0, "strobe clears count");
      chk_rd(`OFS_CONTROL, CKX, "strobe reads zero");
      $display("Test external clock done");
      wr(`OFS_PRESCALE, 32'h0);
      wr(`OFS_CMP_A, 32'h3);
      start(MIE);
      idle(40);
      chk_bit(irq, 1'b1, "match request");
      rd(`OFS_COUNT);
      chk_bit(rd_val <= 32'h3, 1'b1, "count wraps at A");
      chk({24'h0, high_w}, 32'h4, "toggle high width");
      chk({24'h0, low_w}, 32'h4, "toggle low width");
      wr(`OFS_CONTROL, MIE);
      chk_rd(`OFS_CONTROL, MIE | 32'h8, "match flag held");
      wr(`OFS_CONTROL, MIE | 32'h8);
      chk_rd(`OFS_CONTROL, MIE, "match flag cleared");
      chk_bit(irq, 1'b0, "request cleared");
      $display("Test interval done");
      wr(`OFS_CMP_A, 32'h9);
      wr(`OFS_CMP_B, 32'h4);
      start(32'h3000);
      idle(50);
      chk({24'h0, high_w}, 32'h4, "pulse high width");
      chk({24'h0, low_w}, 32'h6, "pulse low width");
      start(32'h2000 | POL);
      idle(40);
      chk_rd(`OFS_CONTROL, 32'h2000 | POL | 32'h8, "one shot stops");
      chk_bit(out_pin, 1'b1, "one shot idle level");
      $display("Test pulse done");
      wr(`OFS_CMP_A, 32'h0000FFFF);
      start(CAPR | CIE);
      idle(20);
      wr(`OFS_CONTROL, CAPR | CIE | RUN | PAU);
      idle(3);
      timer_pins_model_inst.cap_set(1'b1);
      idle(4);
      rd(`OFS_COUNT);
      chk_rd(`OFS_CAPTURE, rd_val, "captured value");
      chk_bit(irq, 1'b1, "capture request");
      chk_bit(out_pin, 1'b0, "no waveform in capture");
      chk_rd(`OFS_CONTROL, CAPR | CIE | RUN | PAU | 32'h4, "capture flag");
      wr(`OFS_CONTROL, CAPR | CIE | RUN | PAU | 32'h4);
      timer_pins_model_inst.cap_set(1'b0);
      idle(4);
      chk_rd(`OFS_CONTROL, CAPR | CIE | RUN | PAU, "falling edge ignored");
      @(posedge clk_sys);
      deep_sleep <= 1'b1;
      timer_pins_model_inst.cap_set(1'b1);
      idle(4);
      chk_rd(`OFS_CONTROL, CAPR | CIE | RUN | PAU, "no flag in deep sleep");
      @(posedge clk_sys);
      deep_sleep <= 1'b0;
      timer_pins_model_inst.cap_set(1'b0);
      start(CAPR | 32'h00040000);
      idle(40);
      rd(`OFS_CONTROL);
      chk_bit(rd_val[2], 1'b1, "oscillator capture");
      $display("Test capture done");
      start(CLE | LIE);
      idle(40);
      timer_pins_model_inst.cap_set(1'b1);
      idle(3);
      timer_pins_model_inst.cap_set(1'b0);
      idle(3);
      rd(`OFS_COUNT);
      chk_bit(rd_val < 32'h8, 1'b1, "clear input resets count");
      chk_bit(irq, 1'b1, "clear input request");
      $display("Test clear input done");
      wr(`OFS_CONTROL, 32'hE);
      // Source changed only while stopped; fast oscillator edges every 4 bus clocks
      pre_sel <= 2'h1;
      wr(`OFS_PRESCALE, 32'h1);
      start(32'h0);
      idle(80);
      rd(`OFS_COUNT);
      chk_bit(rd_val >= 32'h6 && rd_val <= 32'hA, 1'b1, "oscillator prescaled count");
      $display("Test prescaler source done");
      final_report();
   end
endmodule : timer_capture_pulse_unit_tb
`default_nettype wire
